// ===== design/rio_pkg.sv
// constants, register map and timing for the relay output and contact input block
// assumes a 100 MHz system clock and an APB slave with 8-bit byte addresses
package rio_pkg;

	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int RIO_N_TRIP = 4;
	localparam int RIO_N_ALARM = 5;
	localparam int RIO_N_REL = 10;
	localparam int RIO_N_DI = 6;
	localparam int RIO_N_SIG = 26;
	localparam int RIO_N_EV = 13;
	localparam int RIO_ALARM_BASE = 4;
	localparam int RIO_SF_IDX = 9;
	localparam int RIO_MA_DROP_LO = 7;
	localparam int RIO_MA_DROP_HI = 8;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] RIO_OFS_CTRL = 8'h00;
	localparam logic [7:0] RIO_OFS_LATCH_EN = 8'h04;
	localparam logic [7:0] RIO_OFS_INVERT = 8'h08;
	localparam logic [7:0] RIO_OFS_FORCE_STATE = 8'h0C;
	localparam logic [7:0] RIO_OFS_RELAY_STATE = 8'h10;
	localparam logic [7:0] RIO_OFS_DIRECT = 8'h14;
	localparam logic [7:0] RIO_OFS_IRQ_STATUS = 8'h18;
	localparam logic [7:0] RIO_OFS_IRQ_MASK = 8'h1C;
	localparam logic [7:0] RIO_OFS_DI_STATE = 8'h20;
	localparam logic [7:0] RIO_OFS_DI_INVERT = 8'h24;
	localparam logic [7:0] RIO_OFS_DI_ON_EV = 8'h28;
	localparam logic [7:0] RIO_OFS_DI_OFF_EV = 8'h2C;
	localparam logic [7:0] RIO_OFS_ROUTE = 8'h40;
	localparam logic [7:0] RIO_OFS_PULSE_LEN = 8'h80;
	localparam logic [7:0] RIO_OFS_DI_DELAY = 8'hA0;
	localparam logic [7:0] RIO_OFS_DI_COUNT = 8'hC0;

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int RIO_CTRL_FORCE = 0;
	localparam int RIO_CTRL_RELEASE = 1;
	localparam int RIO_CTRL_MA = 2;
	localparam int RIO_EV_ON_LSB = 0;
	localparam int RIO_EV_OFF_LSB = 6;
	localparam int RIO_EV_TIMEOUT = 12;
	localparam logic [9:0] RIO_RST_REL = 10'h000;
	localparam logic [5:0] RIO_RST_DI = 6'h00;

	// ----------------------------------------
	// limits, in 10 ms ticks
	// ----------------------------------------
	localparam logic [13:0] RIO_PULSE_MAX = 14'h270E;
	localparam logic [13:0] RIO_PULSE_INF = 14'h270F;
	localparam logic [12:0] RIO_DELAY_MAX = 13'h1770;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam longint RIO_CLK_HZ = 100_000_000;
	localparam longint RIO_TICK_MS = 10;
	localparam longint RIO_FORCE_MIN = 5;
	localparam logic [19:0] RIO_TICK_CYC = 20'(RIO_CLK_HZ / 1000 * RIO_TICK_MS);
	localparam logic [35:0] RIO_FORCE_CYC = 36'(RIO_FORCE_MIN * 60 * RIO_CLK_HZ);

endpackage : rio_pkg

// ===== design/rio_din_if.sv
// signals between the relay core and the contact input conditioner
// assumes both ends share one clock
`timescale 1ns/1ps
`default_nettype none
interface rio_din_if;
	logic tick;
	logic [5:0] raw;
	logic [5:0] inv;
	logic [5:0][12:0] delay;
	logic pre_we;
	logic [2:0] pre_idx;
	logic [15:0] pre_val;
	logic [5:0] state;
	logic [5:0][15:0] cnt;
	logic [5:0] ev_on;
	logic [5:0] ev_off;
	modport ctl (output tick, raw, inv, delay, pre_we, pre_idx, pre_val,
		input state, cnt, ev_on, ev_off);
	modport din (input tick, raw, inv, delay, pre_we, pre_idx, pre_val,
		output state, cnt, ev_on, ev_off);
endinterface : rio_din_if
`default_nettype wire

// ===== design/rio_din.sv
// contact input conditioner: polarity, definite delay, edge counters
// assumes raw levels are already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
module rio_din (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// link to relay core
	rio_din_if.din bus
);
	import rio_pkg::*;

	typedef struct packed {
		logic [5:0] state;
		logic [5:0][15:0] cnt;
		logic [5:0][12:0] tmr;
		logic [5:0] ev_on;
		logic [5:0] ev_off;
	} rio_din_s;

	rio_din_s q;
	rio_din_s d;
	logic [5:0] lvl;

	always_comb
	begin
		d = q;
		d.ev_on = RIO_RST_DI;
		d.ev_off = RIO_RST_DI;
		lvl = bus.raw ^ bus.inv; // [R15]
		for (int i = 0; i < RIO_N_DI; i++)
		begin
			if (lvl[i] == q.state[i])
			begin
				d.tmr[i] = '0;
			end
			else if (q.tmr[i] >= bus.delay[i]) // [R11] [R14]
			begin
				// same delay for both directions
				d.state[i] = lvl[i];
				d.tmr[i] = '0;
				d.ev_on[i] = lvl[i];
				d.ev_off[i] = !lvl[i];
				if (lvl[i])
				begin
					d.cnt[i] = q.cnt[i] + 16'h0001; // [R16]
				end
			end
			else if (bus.tick)
			begin
				d.tmr[i] = q.tmr[i] + 13'h0001;
			end
			if (bus.pre_we && (32'(bus.pre_idx) == i))
			begin
				d.cnt[i] = bus.pre_val; // [R16]
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	assign bus.state = q.state;
	assign bus.cnt = q.cnt;
	assign bus.ev_on = q.ev_on;
	assign bus.ev_off = q.ev_off;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_delay_zero;
		(bus.delay[1] == 13'h0000 && lvl[1] != q.state[1]) |=> q.state[1] != $past(q.state[1]);
	endproperty
	a_delay_zero: assert property (p_delay_zero) else $error("zero delay not taken at once"); // [R14]

	property p_delay_hold;
		(lvl[0] != q.state[0] && q.tmr[0] < bus.delay[0]) |=> $stable(q.state[0]);
	endproperty
	a_delay_hold: assert property (p_delay_hold) else $error("input changed before delay"); // [R11]

	property p_active_edge;
		q.ev_on[0] |-> q.state[0] && !$past(q.state[0]);
	endproperty
	a_active_edge: assert property (p_active_edge) else $error("active edge misreported"); // [R15]

	property p_edge_count;
		(q.ev_on[1] && !$past(bus.pre_we)) |-> q.cnt[1] == $past(q.cnt[1]) + 16'h0001;
	endproperty
	a_edge_count: assert property (p_edge_count) else $error("edge counter missed"); // [R16]

	c_input_on: cover property (q.ev_on[0]);
endmodule : rio_din
`default_nettype wire

// ===== design/rio_relay_io.sv
// relay output routing, latching, forcing, remote pulses and contact inputs
// assumes an APB master on clk and asynchronous contact and strap pins
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// R01 - any internal signal routes to each relay through a mask matrix
// R02 - each relay is latched or non-latched by its own setting
// R03 - with the current output option the two top alarm relays are absent
// R04 - every relay output polarity can be inverted
// R05 - forced relay states are writable only while force flag is set
// R06 - one force flag covers all relays and detection stage status
// R07 - force flag and forced states clear after five minutes
// R08 - remote alarm pulse lasts a programmed 0.00 to 99.98 s
// R09 - 99.99 s means unlimited; writing zero ends the pulse
// R10 - six contact inputs are provided
// R11 - each input has polarity and a delay before accepting a change
// R12 - conditioned inputs feed routing, blocking and user logic
// R13 - the configurer should select ac mode for ac-driven inputs; this block has no ac input mode to select
// R14 - input delay is 0.00 to 60.00 s, same both directions
// R15 - normal input active edge is rising, inverted input falling
// R16 - each input counts active edges, 0 to 65535, presettable
// R17 - each input has separate active and inactive edge event enables
// R18 - when forcing ends each relay resumes its normal derived state
module rio_relay_io #(
	parameter logic [35:0] FORCE_CYC = rio_pkg::RIO_FORCE_CYC,
	parameter logic [19:0] TICK_CYC = rio_pkg::RIO_TICK_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins and internal sources
	input wire logic [rio_pkg::RIO_N_DI-1:0] contact_raw,
	input wire logic ma_option,
	input wire logic [rio_pkg::RIO_N_SIG-1:0] internal_sigs,
	// relay outputs
	output logic [rio_pkg::RIO_N_TRIP-1:0] trip_relay_outputs,
	output logic [rio_pkg::RIO_N_ALARM-1:0] alarm_relay_outputs,
	output logic service_status_relay,
	// conditioned inputs, stage forcing, interrupt
	output logic [rio_pkg::RIO_N_DI-1:0] contact_inputs,
	output logic stage_force,
	output logic irq
);
	import rio_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [5:0] di_s1;
		logic [5:0] di_s2;
		logic ma_s1;
		logic ma_s2;
		logic force_on;
		logic [9:0] latch_en;
		logic [9:0] invert;
		logic [9:0] fstate;
		logic [9:0] latched;
		logic [9:0] rel_out;
		logic [35:0] fcnt;
		logic [19:0] tick_cnt;
		logic tick;
		logic [4:0] pact;
		logic [4:0][13:0] pcnt;
		logic [4:0][13:0] plen;
		logic [9:0][31:0] route;
		logic [5:0] di_inv;
		logic [5:0] on_en;
		logic [5:0] off_en;
		logic [5:0][12:0] delay;
		logic [12:0] ists;
		logic [12:0] imask;
		logic irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} rio_main_s;

	rio_main_s q;
	rio_main_s d;
	rio_din_if din ();

	logic [31:0] srcs;
	logic [9:0] src;
	logic [9:0] act;
	logic [9:0] stat;
	logic [12:0] ev_set;
	logic [12:0] ev_clr;
	logic wr;
	logic rel_latch;
	logic [31:0] rd;
	logic rd_ok;
	logic [3:0] pre_i;

	// ----------------------------------------
	// address window decode
	// ----------------------------------------
	function automatic logic rio_win_hit(input logic [7:0] a, input logic [7:0] base,
		input logic [3:0] n);
		logic [8:0] top;
		top = {1'b0, base} + {3'b000, n, 2'b00};
		return (a >= base) && ({1'b0, a} < top) && (a[1:0] == 2'b00);
	endfunction : rio_win_hit

	function automatic logic [3:0] rio_win_idx(input logic [7:0] a, input logic [7:0] base);
		logic [7:0] off;
		off = a - base;
		return off[5:2];
	endfunction : rio_win_idx

	rio_din u_din (
		.clk(clk),
		.rst_n(rst_n),
		.bus(din.din)
	);

	assign din.tick = q.tick;
	assign din.raw = q.di_s2;
	assign din.inv = q.di_inv;
	assign din.delay = q.delay;
	assign din.pre_we = wr && rio_win_hit(paddr, RIO_OFS_DI_COUNT, 4'h6);
	assign pre_i = rio_win_idx(paddr, RIO_OFS_DI_COUNT);
	assign din.pre_idx = pre_i[2:0];
	assign din.pre_val = pwdata[15:0];

	assign wr = psel && penable && q.pready && pwrite && !q.pslverr;
	assign rel_latch = wr && (paddr == RIO_OFS_CTRL) && pwdata[RIO_CTRL_RELEASE];

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always_comb
	begin
		rd = '0;
		rd_ok = 1'b1;
		if (paddr == RIO_OFS_CTRL)
		begin
			rd[RIO_CTRL_FORCE] = q.force_on;
			rd[RIO_CTRL_MA] = q.ma_s2;
		end
		else if (paddr == RIO_OFS_LATCH_EN) rd[9:0] = q.latch_en;
		else if (paddr == RIO_OFS_INVERT) rd[9:0] = q.invert;
		else if (paddr == RIO_OFS_FORCE_STATE) rd[9:0] = q.fstate;
		else if (paddr == RIO_OFS_RELAY_STATE) rd[9:0] = q.rel_out;
		else if (paddr == RIO_OFS_DIRECT) rd[4:0] = q.pact;
		else if (paddr == RIO_OFS_IRQ_STATUS) rd[12:0] = q.ists;
		else if (paddr == RIO_OFS_IRQ_MASK) rd[12:0] = q.imask;
		else if (paddr == RIO_OFS_DI_STATE) rd[5:0] = din.state;
		else if (paddr == RIO_OFS_DI_INVERT) rd[5:0] = q.di_inv;
		else if (paddr == RIO_OFS_DI_ON_EV) rd[5:0] = q.on_en;
		else if (paddr == RIO_OFS_DI_OFF_EV) rd[5:0] = q.off_en;
		else if (rio_win_hit(paddr, RIO_OFS_ROUTE, 4'hA))
			rd = q.route[rio_win_idx(paddr, RIO_OFS_ROUTE)];
		else if (rio_win_hit(paddr, RIO_OFS_PULSE_LEN, 4'h5))
			rd[13:0] = q.plen[rio_win_idx(paddr, RIO_OFS_PULSE_LEN)];
		else if (rio_win_hit(paddr, RIO_OFS_DI_DELAY, 4'h6))
			rd[12:0] = q.delay[rio_win_idx(paddr, RIO_OFS_DI_DELAY)];
		else if (rio_win_hit(paddr, RIO_OFS_DI_COUNT, 4'h6))
			rd[15:0] = din.cnt[rio_win_idx(paddr, RIO_OFS_DI_COUNT)];
		else rd_ok = 1'b0;
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		d = q;
		d.di_s1 = contact_raw;
		d.di_s2 = q.di_s1;
		d.ma_s1 = ma_option;
		d.ma_s2 = q.ma_s1;
		ev_set = '0;
		ev_clr = '0;

		// 10 ms time base for delays and pulses
		d.tick = (q.tick_cnt == TICK_CYC - 20'h0_0001);
		d.tick_cnt = d.tick ? 20'h0_0000 : q.tick_cnt + 20'h0_0001;

		// routing and latching
		srcs = {internal_sigs, din.state}; // [R12]
		for (int k = 0; k < RIO_N_REL; k++)
		begin
			src[k] = |(q.route[k] & srcs); // [R01]
		end
		src[RIO_ALARM_BASE +: RIO_N_ALARM] = src[RIO_ALARM_BASE +: RIO_N_ALARM] | q.pact;
		d.latched = rel_latch ? RIO_RST_REL : ((q.latched | src) & q.latch_en); // [R02]
		act = (src | (q.latched & q.latch_en));
		// normal state is recomputed every cycle so it is ready when forcing stops
		stat = q.force_on ? q.fstate : act; // [R06] [R18]
		d.rel_out = stat ^ q.invert; // [R04]
		if (q.ma_s2)
		begin
			// those relay drivers belong to the current outputs then
			d.rel_out[RIO_MA_DROP_HI:RIO_MA_DROP_LO] = 2'b00; // [R03]
		end

		// force watchdog
		d.fcnt = q.force_on ? q.fcnt + 36'h0_0000_0001 : 36'h0_0000_0000;
		if (q.force_on && q.fcnt == FORCE_CYC - 36'h0_0000_0001)
		begin
			d.force_on = 1'b0; // [R07]
			d.fstate = RIO_RST_REL;
			d.fcnt = '0;
			ev_set[RIO_EV_TIMEOUT] = 1'b1;
		end

		// remote alarm pulses
		for (int a = 0; a < RIO_N_ALARM; a++)
		begin
			if (q.tick && q.pact[a] && q.plen[a] != RIO_PULSE_INF) // [R09]
			begin
				d.pact[a] = q.pcnt[a] > 14'h0001; // [R08]
				d.pcnt[a] = q.pcnt[a] - 14'h0001;
			end
		end

		// input events
		ev_set[RIO_EV_ON_LSB +: RIO_N_DI] = din.ev_on & q.on_en; // [R17]
		ev_set[RIO_EV_OFF_LSB +: RIO_N_DI] = din.ev_off & q.off_en; // [R17]

		// register writes
		if (wr)
		begin
			if (paddr == RIO_OFS_CTRL)
			begin
				d.force_on = pwdata[RIO_CTRL_FORCE]; // [R06]
				d.fstate = pwdata[RIO_CTRL_FORCE] ? d.fstate : RIO_RST_REL; // [R18]
			end
			else if (paddr == RIO_OFS_LATCH_EN) d.latch_en = pwdata[9:0];
			else if (paddr == RIO_OFS_INVERT) d.invert = pwdata[9:0];
			else if (paddr == RIO_OFS_FORCE_STATE)
			begin
				if (q.force_on)
				begin
					d.fstate = pwdata[9:0]; // [R05]
				end
			end
			else if (paddr == RIO_OFS_DIRECT)
			begin
				for (int a = 0; a < RIO_N_ALARM; a++)
				begin
					d.pact[a] = pwdata[a] && (q.plen[a] != 14'h0000); // [R08] [R09]
					d.pcnt[a] = q.plen[a];
				end
			end
			else if (paddr == RIO_OFS_IRQ_STATUS) ev_clr = pwdata[12:0];
			else if (paddr == RIO_OFS_IRQ_MASK) d.imask = pwdata[12:0];
			else if (paddr == RIO_OFS_DI_INVERT) d.di_inv = pwdata[5:0];
			else if (paddr == RIO_OFS_DI_ON_EV) d.on_en = pwdata[5:0];
			else if (paddr == RIO_OFS_DI_OFF_EV) d.off_en = pwdata[5:0];
			else if (rio_win_hit(paddr, RIO_OFS_ROUTE, 4'hA))
				d.route[rio_win_idx(paddr, RIO_OFS_ROUTE)] = pwdata;
			else if (rio_win_hit(paddr, RIO_OFS_PULSE_LEN, 4'h5))
				d.plen[rio_win_idx(paddr, RIO_OFS_PULSE_LEN)] =
					(pwdata[13:0] > RIO_PULSE_INF) ? RIO_PULSE_INF : pwdata[13:0];
			else if (rio_win_hit(paddr, RIO_OFS_DI_DELAY, 4'h6))
				d.delay[rio_win_idx(paddr, RIO_OFS_DI_DELAY)] = // [R14]
					(pwdata[12:0] > RIO_DELAY_MAX) ? RIO_DELAY_MAX : pwdata[12:0];
		end

		// sticky events: a new event beats a clear in the same cycle
		d.ists = (q.ists & ~ev_clr) | ev_set;
		d.irq = |(q.ists & q.imask);

		// apb: answer one cycle after setup, zero wait in access
		d.pready = 1'b0;
		d.pslverr = 1'b0;
		if (psel && !penable)
		begin
			d.pready = 1'b1;
			d.pslverr = !rd_ok;
			d.prdata = rd;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign trip_relay_outputs = q.rel_out[RIO_N_TRIP-1:0];
	assign alarm_relay_outputs = q.rel_out[RIO_ALARM_BASE +: RIO_N_ALARM];
	assign service_status_relay = q.rel_out[RIO_SF_IDX];
	assign contact_inputs = din.state; // [R10] [R12]
	assign stage_force = q.force_on; // [R06]
	assign irq = q.irq;
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_route_follow;
		(!q.force_on && !q.latch_en[0] && !q.invert[0]) |=> trip_relay_outputs[0] == $past(src[0]);
	endproperty
	a_route_follow: assert property (p_route_follow) else $error("relay ignores route"); // [R01]
	property p_latch_hold;
		(q.latched[0] && q.latch_en[0] && !rel_latch && !q.force_on && !q.invert[0])
			|=> trip_relay_outputs[0];
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latched relay dropped"); // [R02]
	property p_ma_drop;
		q.ma_s2 |=> alarm_relay_outputs[4:3] == 2'b00;
	endproperty
	a_ma_drop: assert property (p_ma_drop) else $error("absent alarm relay driven"); // [R03]
	property p_invert;
		(q.force_on && q.invert[0]) |=> trip_relay_outputs[0] == !$past(q.fstate[0]);
	endproperty
	a_invert: assert property (p_invert) else $error("inversion not applied"); // [R04]
	property p_force_gate;
		(wr && paddr == RIO_OFS_FORCE_STATE && !q.force_on) |=> $stable(q.fstate);
	endproperty
	a_force_gate: assert property (p_force_gate) else $error("forced state written unforced"); // [R05]
	property p_force_common;
		(q.force_on && !q.invert[RIO_SF_IDX] && !wr && q.fcnt != FORCE_CYC - 36'h0_0000_0001)
			|=> stage_force && service_status_relay == $past(q.fstate[RIO_SF_IDX]);
	endproperty
	a_force_common: assert property (p_force_common) else $error("force not common"); // [R06]
	property p_force_timeout;
		(q.force_on && q.fcnt == FORCE_CYC - 36'h0_0000_0001 && !wr)
			|=> !q.force_on && q.fstate == RIO_RST_REL && q.ists[RIO_EV_TIMEOUT];
	endproperty
	a_force_timeout: assert property (p_force_timeout) else $error("force timeout missed"); // [R07]
	property p_pulse_start;
		(wr && paddr == RIO_OFS_DIRECT && pwdata[0] && q.plen[0] != 14'h0000)
			|=> q.pact[0] && q.pcnt[0] == $past(q.plen[0]) ##1 alarm_relay_outputs[0] != q.invert[4];
	endproperty
	a_pulse_start: assert property (p_pulse_start) else $error("remote pulse not started"); // [R08]
	property p_pulse_inf;
		(q.pact[0] && q.plen[0] == RIO_PULSE_INF && !wr) |=> q.pact[0];
	endproperty
	a_pulse_inf: assert property (p_pulse_inf) else $error("infinite pulse ended"); // [R09]
	property p_pulse_stop;
		(wr && paddr == RIO_OFS_DIRECT && !pwdata[0]) |=> !q.pact[0];
	endproperty
	a_pulse_stop: assert property (p_pulse_stop) else $error("zero write did not release"); // [R09]
	property p_force_resume;
		(!q.force_on && $past(q.force_on) && !q.latch_en[3] && !q.invert[3])
			|=> trip_relay_outputs[3] == $past(src[3]);
	endproperty
	a_force_resume: assert property (p_force_resume) else $error("no resume after force"); // [R18]
	c_timeout: cover property (q.force_on ##1 !q.force_on && q.ists[RIO_EV_TIMEOUT]);
	c_pulse_end: cover property (q.pact[0] ##1 !q.pact[0]);
	c_irq: cover property (irq);
endmodule : rio_relay_io
`default_nettype wire

// ===== bench/test_relay_output_and_input_control.sv
// self-checking bench for the relay output and contact input block
// assumes short force and tick counts given as parameters, apb master driven here
`timescale 1ns/1ps
`default_nettype none
module test_relay_output_and_input_control;
	import rio_pkg::*;

	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam logic [35:0] F_CYC = 36'h0_0000_00C8;
	localparam logic [19:0] T_CYC = 20'h0_0004;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, ma_option;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [5:0] contact_raw, ci;
	logic [25:0] internal_sigs;
	logic [3:0] trip;
	logic [4:0] alarm;
	logic sf, stage_force, irq, err;
	int fails, total_checks, cyc, seed, k;
	logic inv;

	rio_relay_io #(.FORCE_CYC(F_CYC), .TICK_CYC(T_CYC)) dut_u (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.contact_raw(contact_raw), .ma_option(ma_option), .internal_sigs(internal_sigs),
		.trip_relay_outputs(trip), .alarm_relay_outputs(alarm),
		.service_status_relay(sf), .contact_inputs(ci), .stage_force(stage_force), .irq(irq));

	// ----------------------------------------
	// clock and timeout
	// ----------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// run needs about 660 cycles, thirty times that is a hang
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			results();
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, e, rdv);
	endtask : rd

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
	endtask : settle

	// expected pin level of a routed, possibly inverted relay
	function automatic logic pin_of(input logic src, input logic iv);
		return src ^ iv;
	endfunction : pin_of

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		seed = 8770;
		rst_n = 1'b0;
		{psel, penable, pwrite, ma_option} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		contact_raw = 6'h00;
		internal_sigs = 26'h000_0000;
		settle(10);
		rst_n <= 1'b1;
		@(posedge clk);
		rd("ctrl", RIO_OFS_CTRL, 32'h0000_0000);
		rd("latch_en", RIO_OFS_LATCH_EN, 32'h0000_0000);
		rd("irq_mask", RIO_OFS_IRQ_MASK, 32'h0000_0000);
		rd("unmapped", 8'hFC, 32'h0000_0000);
		chk("pslverr", 32'h0000_0001, {31'h0, err});
		// routing and polarity with random sources
		for (int i = 0; i < 8; i++)
		begin
			k = {$random(seed)} % RIO_N_SIG;
			inv = 1'($random(seed));
			wr(RIO_OFS_ROUTE + 8'h0C, 32'h0000_0001 << (k + 6));
			wr(RIO_OFS_INVERT, {28'h0, inv, 3'h0});
			internal_sigs <= 26'($random(seed));
			settle(4);
			chk("trip3", {31'h0, pin_of(internal_sigs[k], inv)}, {31'h0, trip[3]});
		end
		// latched against non-latched
		wr(RIO_OFS_INVERT, 32'h0000_0000);
		wr(RIO_OFS_ROUTE, 32'h0000_0040);
		wr(RIO_OFS_ROUTE + 8'h08, 32'h0000_0040);
		wr(RIO_OFS_LATCH_EN, 32'h0000_0001);
		internal_sigs <= 26'h000_0001;
		settle(4);
		chk("latch on", 32'h0000_0005, {28'h0, trip & 4'h5});
		internal_sigs <= 26'h000_0000;
		settle(4);
		chk("latch hold", 32'h0000_0001, {28'h0, trip & 4'h5});
		wr(RIO_OFS_CTRL, 32'h0000_0002);
		settle(3);
		chk("latch release", 32'h0000_0000, {28'h0, trip & 4'h5});
		for (int r = 0; r < 4; r++)
			wr(RIO_OFS_ROUTE + 8'(4 * r), 32'h0000_0000);
		wr(RIO_OFS_INVERT, 32'h0000_0001);
		// remote pulse, finite then unlimited
		wr(RIO_OFS_PULSE_LEN, 32'h0000_0003);
		wr(RIO_OFS_DIRECT, 32'h0000_0001);
		settle(1);
		chk("pulse on", 32'h0000_0001, {27'h0, alarm});
		settle(16);
		chk("pulse off", 32'h0000_0000, {27'h0, alarm});
		wr(RIO_OFS_PULSE_LEN, {18'h0, RIO_PULSE_INF});
		wr(RIO_OFS_DIRECT, 32'h0000_0001);
		settle(100);
		chk("pulse inf", 32'h0000_0001, {27'h0, alarm});
		rd("direct", RIO_OFS_DIRECT, 32'h0000_0001);
		wr(RIO_OFS_DIRECT, 32'h0000_0000);
		settle(3);
		chk("pulse stop", 32'h0000_0000, {27'h0, alarm});
		// forcing, option strap, timeout and interrupt
		wr(RIO_OFS_FORCE_STATE, 32'h0000_03FF);
		rd("force refused", RIO_OFS_FORCE_STATE, 32'h0000_0000);
		wr(RIO_OFS_IRQ_MASK, 32'h0000_1001);
		wr(RIO_OFS_CTRL, 32'h0000_0001);
		wr(RIO_OFS_FORCE_STATE, 32'h0000_03FF);
		settle(2);
		chk("stage_force", 32'h0000_0001, {31'h0, stage_force});
		chk("forced", 32'h0000_03FE, {22'h0, sf, alarm, trip});
		ma_option <= 1'b1;
		settle(6);
		chk("ma alarm", 32'h0000_0007, {27'h0, alarm});
		rd("ctrl ma", RIO_OFS_CTRL, 32'h0000_0005);
		ma_option <= 1'b0;
		settle(220);
		chk("timeout flag", 32'h0000_0000, {31'h0, stage_force});
		chk("resumed", 32'h0000_0001, {22'h0, sf, alarm, trip});
		chk("irq timeout", 32'h0000_0001, {31'h0, irq});
		rd("status", RIO_OFS_IRQ_STATUS, 32'h0000_1000);
		rd("force cleared", RIO_OFS_FORCE_STATE, 32'h0000_0000);
		wr(RIO_OFS_IRQ_STATUS, 32'h0000_1000);
		settle(2);
		chk("irq clear", 32'h0000_0000, {31'h0, irq});
		// contact input delay, counter preset, events, routing
		// contacts are dry dc levels here, so no ac input mode is selected
		wr(RIO_OFS_DI_DELAY, 32'h0000_0005);
		wr(RIO_OFS_DI_COUNT, 32'h0000_FFFE);
		wr(RIO_OFS_DI_ON_EV, 32'h0000_0001);
		wr(RIO_OFS_ROUTE + 8'h04, 32'h0000_0001);
		contact_raw <= 6'h01;
		settle(10);
		chk("di delay", 32'h0000_0000, {31'h0, ci[0]});
		settle(20);
		chk("di on", 32'h0000_0001, {31'h0, ci[0]});
		chk("di route", 32'h0000_0001, {31'h0, trip[1]});
		chk("irq di", 32'h0000_0001, {31'h0, irq});
		rd("di count", RIO_OFS_DI_COUNT, 32'h0000_FFFF);
		contact_raw <= 6'h00;
		settle(30);
		chk("di off", 32'h0000_0000, {31'h0, ci[0]});
		rd("off ev disabled", RIO_OFS_IRQ_STATUS, 32'h0000_0001);
		rd("count hold", RIO_OFS_DI_COUNT, 32'h0000_FFFF);
		wr(RIO_OFS_IRQ_STATUS, 32'h0000_0001);
		// inverted input: low raw level is active, rising raw level is the inactive edge
		wr(RIO_OFS_DI_OFF_EV, 32'h0000_0002);
		wr(RIO_OFS_DI_INVERT, 32'h0000_0002);
		settle(8);
		rd("di state inv", RIO_OFS_DI_STATE, 32'h0000_0002);
		rd("inv count", RIO_OFS_DI_COUNT + 8'h04, 32'h0000_0001);
		contact_raw <= 6'h02;
		settle(8);
		chk("inv off", 32'h0000_0000, {26'h0, ci});
		rd("off ev", RIO_OFS_IRQ_STATUS, 32'h0000_0080);
		rd("inv count hold", RIO_OFS_DI_COUNT + 8'h04, 32'h0000_0001);
		results();
	end
endmodule : test_relay_output_and_input_control
`default_nettype wire
